// >>> logic/csb_pkg.sv
// constants, types and register map of the core status and bank select block
package csb_pkg;

  // special register offsets in the data memory map
  localparam logic [7:0] A_IND0     = 8'h00; // indirect through first pointer
  localparam logic [7:0] A_MPTR0    = 8'h01;
  localparam logic [7:0] A_IND1     = 8'h02; // indirect through second pointer
  localparam logic [7:0] A_MPTR1    = 8'h03;
  localparam logic [7:0] A_BANK     = 8'h04;
  localparam logic [7:0] A_ACC      = 8'h05;
  localparam logic [7:0] A_PC_LOW   = 8'h06;
  localparam logic [7:0] A_TPTR_LO  = 8'h07;
  localparam logic [7:0] A_TBL_HI   = 8'h08;
  localparam logic [7:0] A_TPTR_HI  = 8'h09;
  localparam logic [7:0] A_FLAGS    = 8'h0A;
  localparam logic [7:0] A_EE_ADDR  = 8'h1E;
  localparam logic [7:0] A_EE_DATA  = 8'h1F;

  // everything below this address is special, above it general purpose
  localparam logic [7:0] SFR_LIMIT  = 8'h80;

  // general purpose storage: 128 bytes per bank, four banks at most
  localparam int         RAM_AW     = 9;
  localparam int         RAM_WORDS  = 512;
  localparam logic [1:0] BANK_ZERO  = 2'h0;

  // bank pointer masks per variant, reset value
  localparam logic [7:0] BANK_MASK_TWO  = 8'h01;
  localparam logic [7:0] BANK_MASK_FOUR = 8'h03;
  localparam logic [7:0] BANK_RST       = 8'h00;

  // flag positions inside the six implemented bits
  localparam int ST_CARRY  = 0;
  localparam int ST_NIBBLE = 1;
  localparam int ST_NULL   = 2;
  localparam int ST_EXCESS = 3;
  localparam int ST_PDOWN  = 4;
  localparam int ST_DOG    = 5;
  localparam logic [5:0] FLAGS_RST = 6'h00;
  localparam logic [1:0] FLAGS_TOP = 2'h0; // unimplemented top bits

  // nonvolatile store: 64 bytes (two-bank) or 128 bytes (four-bank)
  localparam int         EE_AW        = 7;
  localparam int         EE_WORDS     = 128;
  localparam logic [6:0] EE_MASK_TWO  = 7'h3F;
  localparam logic [6:0] EE_MASK_FOUR = 7'h7F;

  // program side widths
  localparam int PC_W   = 12;
  localparam int PROG_W = 16;

  // instruction classes of the arithmetic request; none and load leave the flags alone
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_ADD  = 4'h1,
    OP_ADC  = 4'h2,
    OP_SUB  = 4'h3,
    OP_SBC  = 4'h4,
    OP_AND  = 4'h5,
    OP_OR   = 4'h6,
    OP_XOR  = 4'h7,
    OP_RLC  = 4'h8,
    OP_RRC  = 4'h9,
    OP_LOAD = 4'hA
  } csb_op_t;

  // low-byte jump sequencer
  typedef enum logic [1:0] {
    JMP_IDLE  = 2'b00,
    JMP_DUMMY = 2'b01
  } csb_jump_t;

  // register access request from the instruction side
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } csb_bus_req_t;

  // arithmetic request: accumulator op operand, result into accumulator
  typedef struct packed {
    logic       valid;
    csb_op_t    op;
    logic [7:0] operand;
  } csb_alu_req_t;

endpackage

// >>> logic/csb_core_regs.sv
// core status, bank select, table read and data store registers
// Notes on behaviour
// - two-bank variant: bit 0 picks bank
// - four-bank variant: two bits pick banks 0-3
// - resets clear bank, except sleeping watchdog expiry
// - special area decodes the same in every bank
// - direct data accesses always land in bank 0
// - unused bank pointer bits read zero
// - low pc write jumps in page, dummy cycle
// - table read: high byte kept, low byte out
// - flag writes never touch expiry or power-down
// - carry from add, no-borrow, rotate through carry
// - nibble carry or nibble no-borrow sets flag
// - zero arithmetic or logic result sets null flag
// - carry into msb differs from out: excess
// - power-down: cleared power-up/clear-dog, set by stop
// - expiry flag: set by dog, cleared power-up/clear-dog/stop
// - status never saved on call or interrupt
// - power-on clears system flags, top bits zero
// - data store 64/128 bytes, one byte access
// - no register-to-register moves, accumulator only
// - second pointer uses bank, first bank 0
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module csb_core_regs
  import csb_pkg::*;
#(
  parameter bit FOUR_BANK = 1'b0
) (
  // clock and power-on reset
  input  wire logic                ref_clk_i,
  input  wire logic                arst_n_i,
  // register access
  input  wire csb_bus_req_t        bus_i,
  output logic [7:0]               rd_data_o,
  // arithmetic requests
  input  wire csb_alu_req_t        alu_i,
  output logic [7:0]               acc_o,
  output logic [7:0]               flags_o,
  // system events
  input  wire logic                sys_rst_i,
  input  wire logic                clear_watchdog_instruction_i,
  input  wire logic                halt_i,
  input  wire logic                wake_i,
  input  wire logic                wdt_expire_i,
  output logic                     sleeping_o,
  // program counter low-byte jump
  input  wire logic [PC_W-1:0]     pc_i,
  output logic                     jump_valid_o,
  output logic [PC_W-1:0]          jump_target_o,
  output logic                     dummy_cycle_o,
  // table read
  input  wire logic                tbl_rd_i,
  input  wire logic [PROG_W-1:0]   prog_word_i,
  output logic                     prog_rd_o,
  output logic [PROG_W-1:0]        prog_addr_o,
  output logic [7:0]               tbl_low_o,
  output logic                     tbl_low_valid_o,
  // nonvolatile store byte transfers
  input  wire logic                ee_rd_i,
  input  wire logic                ee_wr_i
);

  // register state
  logic [7:0] mptr0;
  logic [7:0] mptr1;
  logic [7:0] bank_sel;
  logic [7:0] acc;
  logic [7:0] tptr_lo;
  logic [7:0] tptr_hi;
  logic [7:0] tbl_hi;
  logic [5:0] flags;
  logic [6:0] ee_addr;
  logic [7:0] ee_data;
  logic [7:0] ram [RAM_WORDS];
  logic [7:0] ee_mem [EE_WORDS];
  csb_jump_t  jump_state;

  // request fields
  logic       bus_wr;
  logic       bus_rd;
  logic [7:0] bus_addr;
  logic [7:0] bus_wdata;
  assign bus_wr    = bus_i.wr;
  assign bus_rd    = bus_i.rd;
  assign bus_addr  = bus_i.addr;
  assign bus_wdata = bus_i.wdata;

  // special register selects; the bank pointer takes no part here
  logic wr_mptr0;
  logic wr_mptr1;
  logic wr_bank;
  logic wr_acc;
  logic wr_pc_low;
  logic wr_tptr_lo;
  logic wr_tptr_hi;
  logic wr_tbl_hi;
  logic wr_flags;
  logic wr_ee_addr;
  logic wr_ee_data;
  assign wr_mptr0   = bus_wr && (bus_addr == A_MPTR0);
  assign wr_mptr1   = bus_wr && (bus_addr == A_MPTR1);
  assign wr_bank    = bus_wr && (bus_addr == A_BANK);
  assign wr_acc     = bus_wr && (bus_addr == A_ACC);
  assign wr_pc_low  = bus_wr && (bus_addr == A_PC_LOW);
  assign wr_tptr_lo = bus_wr && (bus_addr == A_TPTR_LO);
  assign wr_tptr_hi = bus_wr && (bus_addr == A_TPTR_HI);
  assign wr_tbl_hi  = bus_wr && (bus_addr == A_TBL_HI);
  assign wr_flags   = bus_wr && (bus_addr == A_FLAGS);
  assign wr_ee_addr = bus_wr && (bus_addr == A_EE_ADDR);
  assign wr_ee_data = bus_wr && (bus_addr == A_EE_DATA);

  // effective data memory target; direct access is pinned to bank 0,
  // the first pointer too, only the second pointer follows the bank
  logic             is_ind0;
  logic             is_ind1;
  logic [7:0]       eff_addr;
  logic [1:0]       eff_bank;
  logic             ram_hit;
  logic [RAM_AW-1:0] ram_idx;
  logic [7:0]       ram_rdata;
  assign is_ind0  = (bus_addr == A_IND0);
  assign is_ind1  = (bus_addr == A_IND1);
  assign eff_addr = is_ind0 ? mptr0 : (is_ind1 ? mptr1 : bus_addr);
  assign eff_bank = is_ind1 ? bank_sel[1:0] : BANK_ZERO;
  // indirect access into the special area is not served (reads zero)
  assign ram_hit  = (eff_addr >= SFR_LIMIT);
  assign ram_idx  = {eff_bank, eff_addr[6:0]};
  assign ram_rdata = ram[ram_idx];

  // bank pointer mask per variant keeps unused bits at zero
  logic [7:0] bank_mask;
  logic [6:0] ee_mask;
  assign bank_mask = FOUR_BANK ? BANK_MASK_FOUR : BANK_MASK_TWO;
  assign ee_mask   = FOUR_BANK ? EE_MASK_FOUR : EE_MASK_TWO;

  // read selection
  logic [7:0] sfr_rdata;
  logic [7:0] next_rd_data;
  assign sfr_rdata =
    (bus_addr == A_MPTR0)   ? mptr0 :
    (bus_addr == A_MPTR1)   ? mptr1 :
    (bus_addr == A_BANK)    ? bank_sel :
    (bus_addr == A_ACC)     ? acc :
    (bus_addr == A_PC_LOW)  ? pc_i[7:0] :
    (bus_addr == A_TPTR_LO) ? tptr_lo :
    (bus_addr == A_TBL_HI)  ? tbl_hi :
    (bus_addr == A_TPTR_HI) ? tptr_hi :
    (bus_addr == A_FLAGS)   ? {FLAGS_TOP, flags} :
    (bus_addr == A_EE_ADDR) ? {1'b0, ee_addr} :
    (bus_addr == A_EE_DATA) ? ee_data : 8'h00;
  assign next_rd_data = ram_hit ? ram_rdata : sfr_rdata;

  // arithmetic unit: always accumulator op operand into the accumulator,
  // so a copy between two data registers has to pass the accumulator
  csb_op_t    op;
  logic       alu_go;
  logic       is_sub;
  logic       is_arith;
  logic       is_logic;
  logic       is_rot;
  logic       cin;
  logic [7:0] b_x;
  logic [8:0] sum9;
  logic [4:0] nib5;
  logic [7:0] low8;
  logic [7:0] logic_res;
  logic [7:0] rot_res;
  logic       rot_c;
  logic [7:0] alu_res;
  assign op       = alu_i.op;
  assign alu_go   = alu_i.valid && (op != OP_NONE);
  assign is_sub   = (op == OP_SUB) || (op == OP_SBC);
  assign is_arith = alu_go && ((op == OP_ADD) || (op == OP_ADC) || is_sub);
  assign is_logic = alu_go && ((op == OP_AND) || (op == OP_OR) ||
                               (op == OP_XOR));
  assign is_rot   = alu_go && ((op == OP_RLC) || (op == OP_RRC));
  // subtraction as add of the inverse: carry out then means no borrow
  assign b_x  = is_sub ? ~alu_i.operand : alu_i.operand;
  assign cin  = (op == OP_SUB) ||
                (((op == OP_ADC) || (op == OP_SBC)) && flags[ST_CARRY]);
  assign sum9 = {1'b0, acc} + {1'b0, b_x} + {8'h00, cin};
  assign nib5 = {1'b0, acc[3:0]} + {1'b0, b_x[3:0]} + {4'h0, cin};
  assign low8 = {1'b0, acc[6:0]} + {1'b0, b_x[6:0]} + {7'h00, cin};
  assign logic_res = (op == OP_AND) ? (acc & alu_i.operand) :
                     (op == OP_OR)  ? (acc | alu_i.operand) :
                                      (acc ^ alu_i.operand);
  assign rot_res = (op == OP_RLC) ? {acc[6:0], flags[ST_CARRY]}
                                  : {flags[ST_CARRY], acc[7:1]};
  assign rot_c   = (op == OP_RLC) ? acc[7] : acc[0];
  assign alu_res = is_arith ? sum9[7:0] :
                   is_logic ? logic_res :
                   is_rot   ? rot_res : alu_i.operand;

  // next flags: a software write loads only the low four bits; an
  // instruction result in the same cycle overrides what it produces
  logic [3:0] flag_base;
  logic       next_carry;
  logic       next_nibble;
  logic       next_null;
  logic       next_excess;
  logic       next_pdown;
  logic       next_dog;
  assign flag_base   = wr_flags ? bus_wdata[3:0] : flags[3:0];
  assign next_carry  = is_arith ? sum9[8] :
                       is_rot   ? rot_c : flag_base[ST_CARRY];
  assign next_nibble = is_arith ? nib5[4] : flag_base[ST_NIBBLE];
  assign next_null   = (is_arith || is_logic) ? (alu_res == 8'h00)
                                              : flag_base[ST_NULL];
  assign next_excess = is_arith ? (low8[7] ^ sum9[8])
                                : flag_base[ST_EXCESS];
  // stop wins over clear-dog if both arrive together
  assign next_pdown  = halt_i | (flags[ST_PDOWN] & ~clear_watchdog_instruction_i);
  // an expiry in the clearing cycle is kept: set beats clear
  assign next_dog    = wdt_expire_i |
                       (flags[ST_DOG] & ~(clear_watchdog_instruction_i | halt_i));

  // status register: no save path exists, calls and interrupt entry
  // stack only the return address outside this block
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flags <= FLAGS_RST;
    end else begin
      flags <= {next_dog, next_pdown, next_excess, next_null,
                next_nibble, next_carry};
    end
  end

  // accumulator: instruction result wins over a software write
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      acc <= 8'h00;
    end else if (alu_go) begin
      acc <= alu_res;
    end else if (wr_acc) begin
      acc <= bus_wdata;
    end
  end

  // sleep state tells a wake-up expiry from a resetting one
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sleeping_o <= 1'b0;
    end else if (wdt_expire_i || wake_i || sys_rst_i) begin
      sleeping_o <= 1'b0;
    end else if (halt_i) begin
      sleeping_o <= 1'b1;
    end
  end

  // bank pointer; an expiry while asleep only wakes, keeping the bank
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bank_sel <= BANK_RST;
    end else if (sys_rst_i || (wdt_expire_i && !sleeping_o)) begin
      bank_sel <= BANK_RST;
    end else if (wr_bank) begin
      bank_sel <= bus_wdata & bank_mask;
    end
  end

  // memory pointers
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mptr0 <= 8'h00;
      mptr1 <= 8'h00;
    end else begin
      if (wr_mptr0) mptr0 <= bus_wdata;
      if (wr_mptr1) mptr1 <= bus_wdata;
    end
  end

  // general purpose storage, one flip-flop byte per entry
  for (genvar gi = 0; gi < RAM_WORDS; gi++) begin : g_ram
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        ram[gi] <= 8'h00;
      end else if (bus_wr && ram_hit &&
                   (ram_idx == RAM_AW'(gi))) begin
        ram[gi] <= bus_wdata;
      end
    end
  end

  // read data stands for exactly the cycle after the strobe
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_data_o <= 8'h00;
    end else begin
      rd_data_o <= bus_rd ? next_rd_data : 8'h00;
    end
  end

  // low-byte jump: target stays in the current page, then one dummy
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      jump_state    <= JMP_IDLE;
      jump_valid_o  <= 1'b0;
      jump_target_o <= '0;
      dummy_cycle_o <= 1'b0;
    end else begin
      jump_valid_o  <= wr_pc_low;
      dummy_cycle_o <= (jump_state == JMP_DUMMY);
      if (wr_pc_low) jump_target_o <= {pc_i[PC_W-1:8], bus_wdata};
      case (jump_state)
        JMP_IDLE: begin
          if (wr_pc_low) jump_state <= JMP_DUMMY;
        end
        JMP_DUMMY: begin
          jump_state <= wr_pc_low ? JMP_DUMMY : JMP_IDLE;
        end
        default: begin
          jump_state <= JMP_IDLE;
        end
      endcase
    end
  end

  // table pointers
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tptr_lo <= 8'h00;
      tptr_hi <= 8'h00;
    end else begin
      if (wr_tptr_lo) tptr_lo <= bus_wdata;
      if (wr_tptr_hi) tptr_hi <= bus_wdata;
    end
  end

  // table read: fetch issued, word returns one cycle later; the fetched
  // high byte wins over a software write landing in the same cycle
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prog_rd_o       <= 1'b0;
      prog_addr_o     <= '0;
      tbl_hi          <= 8'h00;
      tbl_low_o       <= 8'h00;
      tbl_low_valid_o <= 1'b0;
    end else begin
      prog_rd_o       <= tbl_rd_i;
      tbl_low_valid_o <= prog_rd_o;
      if (tbl_rd_i) prog_addr_o <= {tptr_hi, tptr_lo};
      if (prog_rd_o) begin
        tbl_hi    <= prog_word_i[15:8];
        tbl_low_o <= prog_word_i[7:0];
      end else if (wr_tbl_hi) begin
        tbl_hi <= bus_wdata;
      end
    end
  end

  // nonvolatile store address and data holding registers
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ee_addr <= 7'h00;
      ee_data <= 8'h00;
    end else begin
      if (wr_ee_addr) ee_addr <= bus_wdata[6:0] & ee_mask;
      if (ee_rd_i) begin
        ee_data <= ee_mem[ee_addr];
      end else if (wr_ee_data) begin
        ee_data <= bus_wdata;
      end
    end
  end

  // store contents: one byte per transfer, never on the data map
  for (genvar gj = 0; gj < EE_WORDS; gj++) begin : g_ee
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        ee_mem[gj] <= 8'h00;
      end else if (ee_wr_i && (ee_addr == EE_AW'(gj))) begin
        ee_mem[gj] <= ee_data;
      end
    end
  end

  // visible copies of internal state, all registered
  assign acc_o   = acc;
  assign flags_o = {FLAGS_TOP, flags};

endmodule

// >>> test/csb_assertions.sv
// port-level checker for the core status and bank select block
`timescale 1ns/1ps
module csb_checker
  import csb_pkg::*;
(
  // clock and power-on reset
  input wire logic              ref_clk_i,
  input wire logic              arst_n_i,
  // register and arithmetic side
  input wire csb_bus_req_t      bus_i,
  input wire logic [7:0]        rd_data_o,
  input wire csb_alu_req_t      alu_i,
  input wire logic [7:0]        acc_o,
  input wire logic [7:0]        flags_o,
  // system events
  input wire logic              clear_watchdog_instruction_i,
  input wire logic              halt_i,
  input wire logic              wdt_expire_i,
  // jump and table read
  input wire logic [PC_W-1:0]   pc_i,
  input wire logic              jump_valid_o,
  input wire logic [PC_W-1:0]   jump_target_o,
  input wire logic              dummy_cycle_o,
  input wire logic              tbl_rd_i,
  input wire logic [PROG_W-1:0] prog_word_i,
  input wire logic              prog_rd_o,
  input wire logic              tbl_low_valid_o,
  input wire logic [7:0]        tbl_low_o
);
  logic [8:0] add_s;
  logic [8:0] sub_s;
  logic [4:0] add_h;
  logic [3:0] add_f;
  logic [7:0] add_r;
  logic       sub_c;
  logic       is_add;
  logic       pc_wr;
  logic       quiet;
  // reference sums from the live accumulator, compared one cycle later
  assign add_s  = {1'b0, acc_o} + {1'b0, alu_i.operand};
  assign sub_s  = {1'b0, acc_o} + {1'b0, ~alu_i.operand} + 9'h001;
  assign add_h  = {1'b0, acc_o[3:0]} + {1'b0, alu_i.operand[3:0]};
  assign add_r  = add_s[7:0];
  assign add_f  = {(acc_o[7] == alu_i.operand[7]) && (add_r[7] != acc_o[7]),
                   add_r == 8'h00, add_h[4], add_s[8]};
  assign sub_c  = sub_s[8];
  assign is_add = alu_i.valid && (alu_i.op == OP_ADD);
  assign pc_wr  = bus_i.wr && (bus_i.addr == A_PC_LOW);
  // a flags write is only judged when nothing else competes for the bits
  assign quiet  = !alu_i.valid && !halt_i && !clear_watchdog_instruction_i && !wdt_expire_i;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  // jump report then its dummy cycle
  sequence s_jump;
    jump_valid_o ##1 dummy_cycle_o;
  endsequence
  // fetch request then low byte handed out
  sequence s_table;
    prog_rd_o ##1 (tbl_low_valid_o &&
      {8'h00, tbl_low_o} == ($past(prog_word_i) & 16'h00FF));
  endsequence

  a_bank_mask: assert property (bus_i.rd && bus_i.addr == A_BANK
    |=> rd_data_o[7:2] == 6'h00) else $error("bank pointer high bits set");
  a_flags_top: assert property (flags_o[7:6] == 2'h0)
    else $error("flags top bits set");
  a_jump_target: assert property (pc_wr |=> jump_valid_o &&
    jump_target_o[7:0] == $past(bus_i.wdata) &&
    ((jump_target_o ^ $past(pc_i)) & 12'hF00) == 12'h000)
    else $error("jump target wrong");
  a_jump_dummy: assert property (pc_wr ##1 !pc_wr |-> s_jump)
    else $error("dummy cycle missing");
  a_table_read: assert property (tbl_rd_i |=> s_table)
    else $error("table read sequence wrong");
  a_dog_set: assert property (wdt_expire_i |=> flags_o[ST_DOG])
    else $error("expiry flag not set");
  a_halt_flags: assert property (halt_i && !wdt_expire_i
    |=> flags_o[ST_PDOWN] && !flags_o[ST_DOG]) else $error("halt flags");
  a_clear_dog: assert property (clear_watchdog_instruction_i && !halt_i &&
    !wdt_expire_i |=> flags_o[5:4] == 2'b00) else $error("clear flags");
  a_flags_write: assert property (bus_i.wr && bus_i.addr == A_FLAGS
    && quiet |=> $stable(flags_o[5:4]) &&
    flags_o[3:0] == $past(bus_i.wdata[3:0])) else $error("flags write");
  a_add_flags: assert property (is_add
    |=> flags_o[3:0] == $past(add_f)) else $error("add flags wrong");
  a_sub_carry: assert property (alu_i.valid && alu_i.op == OP_SUB
    |=> flags_o[ST_CARRY] == $past(sub_c)) else $error("sub carry wrong");
  a_add_acc: assert property (is_add
    |=> acc_o == $past(add_r)) else $error("add result wrong");
endmodule

bind csb_core_regs csb_checker u_csb_checker (
  .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .bus_i(bus_i),
  .rd_data_o(rd_data_o), .alu_i(alu_i), .acc_o(acc_o), .flags_o(flags_o),
  .clear_watchdog_instruction_i(clear_watchdog_instruction_i), .halt_i(halt_i), .wdt_expire_i(wdt_expire_i),
  .pc_i(pc_i), .jump_valid_o(jump_valid_o), .jump_target_o(jump_target_o),
  .dummy_cycle_o(dummy_cycle_o), .tbl_rd_i(tbl_rd_i),
  .prog_word_i(prog_word_i), .prog_rd_o(prog_rd_o),
  .tbl_low_valid_o(tbl_low_valid_o), .tbl_low_o(tbl_low_o)
);

// >>> test/test_core_status_bank_select.sv
// self-checking bench for the core status and bank select registers
`timescale 1ns/1ps
module test_core_status_bank_select;
  import csb_pkg::*;
  // stimulus, launched just after rising edges
  logic              ref_clk_i;
  logic              arst_n_i;
  csb_bus_req_t      bus;
  csb_alu_req_t      alu;
  logic [7:0]        evs;
  logic [PC_W-1:0]   pc;
  logic [PROG_W-1:0] pword;
  // observed outputs
  logic [7:0]        rdata;
  logic [7:0]        rdata2;
  logic [7:0]        acc;
  logic [7:0]        flags;
  logic [7:0]        tlow;
  logic              sleeping;
  logic              jv;
  logic              dummy;
  logic              prd;
  logic              tvalid;
  logic [PC_W-1:0]   jtgt;
  logic [PROG_W-1:0] paddr;
  int                fail_count;
  int                compares;
  // event bits: reset, clear dog, halt, wake, expiry, table, store rd/wr
  localparam logic [7:0] E_SYS  = 8'h80;
  localparam logic [7:0] E_CLR  = 8'h40;
  localparam logic [7:0] E_HALT = 8'h20;
  localparam logic [7:0] E_WAKE = 8'h10;
  localparam logic [7:0] E_WDT  = 8'h08;
  localparam logic [7:0] E_TBL  = 8'h04;
  localparam logic [7:0] E_EERD = 8'h02;
  localparam logic [7:0] E_EEWR = 8'h01;

  csb_core_regs #(.FOUR_BANK(1'b1)) u_csb_core_regs (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
    .bus_i(bus), .rd_data_o(rdata), .alu_i(alu), .acc_o(acc),
    .flags_o(flags), .sys_rst_i(evs[7]), .clear_watchdog_instruction_i(evs[6]),
    .halt_i(evs[5]), .wake_i(evs[4]), .wdt_expire_i(evs[3]),
    .sleeping_o(sleeping), .pc_i(pc), .jump_valid_o(jv),
    .jump_target_o(jtgt), .dummy_cycle_o(dummy), .tbl_rd_i(evs[2]),
    .prog_word_i(pword), .prog_rd_o(prd), .prog_addr_o(paddr),
    .tbl_low_o(tlow), .tbl_low_valid_o(tvalid), .ee_rd_i(evs[1]),
    .ee_wr_i(evs[0])
  );

  // two-bank variant on the same stimulus, only its read data is judged
  csb_core_regs #(.FOUR_BANK(1'b0)) u_csb_core_regs_two (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
    .bus_i(bus), .rd_data_o(rdata2), .alu_i(alu), .acc_o(),
    .flags_o(), .sys_rst_i(evs[7]), .clear_watchdog_instruction_i(evs[6]),
    .halt_i(evs[5]), .wake_i(evs[4]), .wdt_expire_i(evs[3]),
    .sleeping_o(), .pc_i(pc), .jump_valid_o(),
    .jump_target_o(), .dummy_cycle_o(), .tbl_rd_i(evs[2]),
    .prog_word_i(pword), .prog_rd_o(), .prog_addr_o(),
    .tbl_low_o(), .tbl_low_valid_o(), .ee_rd_i(evs[1]),
    .ee_wr_i(evs[0])
  );

  // 50 MHz clock
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  task automatic wrap_up();
    if (fail_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    compares++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk_i);
    bus.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so look there
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    @(posedge ref_clk_i);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge ref_clk_i);
    bus.rd <= 1'b0;
    #1 chk(n, {8'h00, e}, {8'h00, rdata});
  endtask

  // one-cycle event pulse; returns inside the cycle after it is taken
  task automatic ev(input logic [7:0] m);
    @(posedge ref_clk_i);
    evs <= m;
    @(posedge ref_clk_i);
    evs <= 8'h00;
    #1;
  endtask

  // preload accumulator and flags, issue one op, check the next cycle
  task automatic op(input csb_op_t o, input logic [7:0] a, input logic [7:0] b,
                    input logic [3:0] f, input logic [7:0] er,
                    input logic [3:0] ef);
    wr(A_ACC, a);
    wr(A_FLAGS, {4'h0, f});
    @(posedge ref_clk_i);
    alu <= '{valid: 1'b1, op: o, operand: b};
    @(posedge ref_clk_i);
    alu.valid <= 1'b0;
    #1 chk("acc", {8'h00, er}, {8'h00, acc});
    chk("arith flags", {12'h000, ef}, {12'h000, flags[3:0]});
  endtask

  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    fail_count++;
    wrap_up();
  end

  initial begin
    fail_count = 0;
    compares = 0;
    arst_n_i = 1'b0;
    bus = '0;
    alu = '0;
    evs = 8'h00;
    pc = 12'h5AB;
    pword = 16'hBEEF;
    repeat (20) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    rd(A_FLAGS, 8'h00, "flags at power-on");
    rd(A_BANK, 8'h00, "bank at power-on");
    wr(A_BANK, 8'hFF);
    rd(A_BANK, 8'h03, "bank mask");
    chk("two-bank mask", 16'h0001, {8'h00, rdata2});
    // tag address 80 of every bank through the second pointer
    wr(A_MPTR1, 8'h80);
    for (int b = 0; b < 4; b++) begin
      wr(A_BANK, 8'(b));
      wr(A_IND1, 8'hA0 + 8'(b));
    end
    for (int b = 0; b < 4; b++) begin
      wr(A_BANK, 8'(b));
      rd(A_IND1, 8'hA0 + 8'(b), "banked indirect");
      rd(A_BANK, 8'(b), "bank seen from bank");
    end
    // bank 3 stays selected: direct and first pointer stay in bank 0
    rd(8'h80, 8'hA0, "direct read");
    wr(A_MPTR0, 8'h80);
    rd(A_IND0, 8'hA0, "first pointer");
    wr(8'h81, 8'h5C);
    wr(A_MPTR1, 8'h81);
    rd(A_IND1, 8'h00, "direct write kept in bank 0");
    ev(E_SYS);
    rd(A_BANK, 8'h00, "bank after reset");
    wr(A_BANK, 8'h01);
    ev(E_HALT);
    chk("sleeping", 16'h0001, {15'h0000, sleeping});
    rd(A_FLAGS, 8'h10, "flags after halt");
    ev(E_WDT);
    rd(A_BANK, 8'h01, "bank after sleeping expiry");
    rd(A_FLAGS, 8'h30, "flags after expiry");
    wr(A_FLAGS, 8'hFF);
    rd(A_FLAGS, 8'h3F, "flags write ones");
    wr(A_FLAGS, 8'h00);
    rd(A_FLAGS, 8'h30, "flags write zeros");
    ev(E_WDT);
    rd(A_BANK, 8'h00, "bank after awake expiry");
    ev(E_CLR);
    rd(A_FLAGS, 8'h00, "flags after clear");
    ev(E_WDT);
    ev(E_HALT);
    rd(A_FLAGS, 8'h10, "halt clears expiry");
    ev(E_WAKE);
    chk("awake", 16'h0000, {15'h0000, sleeping});
    // every op class except none, with carry-in and flag boundaries
    op(OP_ADD, 8'hFF, 8'h01, 4'h0, 8'h00, 4'h7);
    op(OP_ADD, 8'h7F, 8'h01, 4'h0, 8'h80, 4'hA);
    op(OP_ADC, 8'h0E, 8'h01, 4'h1, 8'h10, 4'h2);
    op(OP_SUB, 8'h05, 8'h05, 4'h0, 8'h00, 4'h7);
    op(OP_SUB, 8'h10, 8'h01, 4'hF, 8'h0F, 4'h1);
    op(OP_SUB, 8'h80, 8'h01, 4'h0, 8'h7F, 4'h9);
    op(OP_SBC, 8'h00, 8'h00, 4'h0, 8'hFF, 4'h0);
    op(OP_AND, 8'hF0, 8'h0F, 4'h0, 8'h00, 4'h4);
    op(OP_OR, 8'h00, 8'h01, 4'h4, 8'h01, 4'h0);
    op(OP_XOR, 8'h5A, 8'h5A, 4'hA, 8'h00, 4'hE);
    op(OP_RLC, 8'h80, 8'h00, 4'h0, 8'h00, 4'h1);
    op(OP_RRC, 8'h00, 8'h00, 4'h1, 8'h80, 4'h0);
    op(OP_LOAD, 8'h00, 8'h00, 4'hF, 8'h00, 4'hF);
    wr(A_PC_LOW, 8'h34);
    #1 chk("jump", 16'h1534, {3'h0, jv, jtgt});
    @(posedge ref_clk_i);
    #1 chk("dummy", 16'h0001, {15'h0000, dummy});
    rd(A_PC_LOW, 8'hAB, "pc low");
    wr(A_TPTR_LO, 8'h12);
    wr(A_TPTR_HI, 8'h34);
    ev(E_TBL);
    chk("fetch", 16'h3412, prd ? paddr : 16'h0000);
    @(posedge ref_clk_i);
    #1 chk("table low", 16'h01EF, {7'h00, tvalid, tlow});
    pword <= 16'h4110;
    rd(A_TBL_HI, 8'hBE, "table high");
    wr(A_EE_ADDR, 8'hFF);
    rd(A_EE_ADDR, 8'h7F, "store address mask");
    chk("two-bank store mask", 16'h003F, {8'h00, rdata2});
    wr(A_EE_DATA, 8'h5A);
    ev(E_EEWR);
    wr(A_EE_DATA, 8'h00);
    ev(E_EERD);
    rd(A_EE_DATA, 8'h5A, "store byte");
    wrap_up();
  end
endmodule
